/* bench/ftxc_mac_model.sv */
// Transmit sink model standing in for the MAC
`timescale 1ns/1ps
`default_nettype none
module ftxc_mac_model (
  input wire logic sys_clk, // Clock
  input wire logic reset, // Async reset
  input wire logic slow, // Stall now and then
  input wire logic mac_tx_valid, // Word offered
  output logic mac_tx_ready // Word taken
);
  logic [3:0] lfsr_q;
  // Pseudo-random stalls keep the hold path busy
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lfsr_q <= 4'h1;
      mac_tx_ready <= 1'b0;
    end else begin
      lfsr_q <= {lfsr_q[2:0], lfsr_q[3] ^ lfsr_q[2]};
      mac_tx_ready <= !slow || lfsr_q[0];
    end
  end
endmodule
`default_nettype wire

/* bench/ftxc_top_monitor.sv */
// Port-level checker for the transmit control block
`timescale 1ns/1ps
`default_nettype none
module ftxc_monitor (
  input wire logic sys_clk, // Clock
  input wire logic reset, // Async reset
  input wire logic [7:0] avs_address, // Address
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Stall
  input wire logic crossover_auto_strap, // Strap
  input wire logic mac_tx_valid, // MAC valid
  input wire logic [31:0] mac_tx_data, // MAC word
  input wire logic mac_tx_ready, // MAC ready
  input wire logic mac_tx_abort, // MAC abort
  input wire logic tx_stat_valid, // Status valid
  input wire logic [31:0] tx_stat_data, // Status word
  input wire logic tx_stat_pop, // Status pop
  input wire logic tx_underrun, // Underrun
  input wire logic [4:0] rx_alloc_kb // RX share
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [2:0] wr_hist_q;
  logic quiet, rd_tx, rd_hw;
  // Flushes land a few cycles after a write, so holds pause near writes
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wr_hist_q <= 3'h0;
    end else begin
      wr_hist_q <= {wr_hist_q[1:0], avs_write};
    end
  end
  // Completed reads of each register
  assign quiet = !avs_write && wr_hist_q == 3'h0;
  assign rd_tx = avs_read && !avs_waitrequest && avs_address == 8'h70;
  assign rd_hw = avs_read && !avs_waitrequest && avs_address == 8'h74;
  AST_ABORT_PAIR: assert property (tx_underrun == mac_tx_abort)
    else $error("underrun and abort differ");
  AST_UNDERRUN_PULSE: assert property (tx_underrun |=> !tx_underrun)
    else $error("underrun longer than one cycle");
  AST_RX_SHARE: assert property (rx_alloc_kb inside {[5'h02:5'h0e]})
    else $error("receive share out of range");
  AST_MAC_HOLD: assert property (
    mac_tx_valid && !mac_tx_ready && quiet
    |=> mac_tx_valid && $stable(mac_tx_data))
    else $error("MAC word dropped before taken");
  AST_STAT_HOLD: assert property (
    tx_stat_valid && !tx_stat_pop && quiet
    |=> tx_stat_valid && $stable(tx_stat_data))
    else $error("status word lost without pop or flush");
  AST_TX_RSVD: assert property (
    rd_tx |-> avs_readdata[31:16] == 16'h0000 && avs_readdata[13:3] == 11'h000)
    else $error("reserved transmit bits not zero");
  AST_HW_RSVD: assert property (
    rd_hw |-> avs_readdata[31:25] == 7'h00 && avs_readdata[23:22] == 2'h0)
    else $error("reserved hardware bits not zero");
  AST_STRAP: assert property (
    rd_hw && $stable(crossover_auto_strap)
    && crossover_auto_strap == $past(crossover_auto_strap, 5)
    && crossover_auto_strap == $past(crossover_auto_strap, 3)
    |-> avs_readdata[24] == crossover_auto_strap)
    else $error("strap bit does not follow pin");
  COV_UNDERRUN: cover property (tx_underrun);
  COV_MAC_STALL: cover property (mac_tx_valid && !mac_tx_ready);
  COV_STAT_POP: cover property (tx_stat_valid && tx_stat_pop);
endmodule
bind ftxc_top ftxc_monitor mon (.sys_clk, .reset, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .crossover_auto_strap,
  .mac_tx_valid, .mac_tx_data, .mac_tx_ready, .mac_tx_abort, .tx_stat_valid,
  .tx_stat_data, .tx_stat_pop, .tx_underrun, .rx_alloc_kb);
`default_nettype wire

/* bench/ftxc_top_test.sv */
// Self-checking bench for the transmit control block
`timescale 1ns/1ps
`default_nettype none
module ftxc_top_test;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0, avs_write = 1'b0, crossover_auto_strap = 1'b1;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, tx_wr_data = 32'h0;
  logic tx_wr_valid = 1'b0, tx_wr_last = 1'b0, tx_stat_pop = 1'b1;
  logic slow = 1'b0;
  logic [31:0] avs_readdata, mac_tx_data, tx_stat_data;
  logic avs_waitrequest, tx_wr_ready, mac_tx_valid, mac_tx_last, mac_tx_ready;
  logic mac_tx_abort, tx_stat_valid, tx_stat_full, tx_underrun, tx_active;
  logic [4:0] rx_alloc_kb, k;
  logic [32:0] st;
  logic [32:0] rq[$], mq[$], sq[$];
  int fail_count = 0, comparisons = 0, underruns = 0, n;
  ftxc_top dut (.sys_clk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .crossover_auto_strap, .tx_wr_valid, .tx_wr_data, .tx_wr_last,
    .tx_wr_ready, .mac_tx_valid, .mac_tx_data, .mac_tx_last, .mac_tx_ready,
    .mac_tx_abort, .tx_stat_valid, .tx_stat_data, .tx_stat_pop,
    .tx_stat_full, .tx_underrun, .tx_active, .rx_alloc_kb);
  ftxc_mac_model mac (.sys_clk, .reset, .slow, .mac_tx_valid, .mac_tx_ready);
  initial forever #2 sys_clk = ~sys_clk;
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One edge of a bounded wait; a spent bound ends the run
  task automatic guard(inout int c);
    @(posedge sys_clk);
    c++;
    if (c > 2000) begin
      fail_count++;
      finish_test();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int c;
    c = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do guard(c); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rq.push_back({1'b0, exp});
    bus(1'b0, a, 32'h0);
  endtask
  // Host words in order; kept ones are expected at the MAC side
  task automatic words(input int cnt, input logic fin, input logic keep);
    logic [31:0] w;
    int c;
    for (int i = 0; i < cnt; i++) begin
      w = $urandom;
      c = 0;
      tx_wr_valid <= 1'b1;
      tx_wr_data <= w;
      tx_wr_last <= fin && i == cnt - 1;
      if (keep) mq.push_back({fin && i == cnt - 1, w});
      do guard(c); while (tx_wr_ready !== 1'b1);
    end
    tx_wr_valid <= 1'b0;
  endtask
  task automatic drain;
    int c;
    c = 0;
    while (mq.size() != 0 || sq.size() != 0) guard(c);
  endtask
  // Each result is compared with the oldest note when it shows
  always @(posedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'b0)
      chk(avs_readdata, rq.size() ? rq.pop_front() : 'x);
    if (mac_tx_valid === 1'b1 && mac_tx_ready)
      chk({mac_tx_last, mac_tx_data}, mq.size() ? mq.pop_front() : 'x);
    if (tx_stat_valid === 1'b1 && tx_stat_pop) begin
      st = sq.size() ? sq.pop_front() : 'x;
      chk(st[32] ? tx_stat_data : tx_stat_data & 32'h80000000, st[31:0]);
    end
    if (tx_underrun === 1'b1) underruns++;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(44683));
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(8'h70, 32'h0);
    rd(8'h74, 32'h01050000);
    chk(rx_alloc_kb, 5'h0b);
    rd(8'h40, 32'h0);
    // Every size code, with the strap moving between reads
    for (int c = 0; c < 16; c++) begin
      crossover_auto_strap <= 1'($urandom);
      bus(1'b1, 8'h74, 32'(c) << 16);
      repeat (4) @(posedge sys_clk);
      k = c < 2 ? 5'h02 : c > 14 ? 5'h0e : 5'(c);
      chk(rx_alloc_kb, 5'h10 - k);
      rd(8'h74, {7'h0, crossover_auto_strap, 4'h0, 4'(c), 16'h0});
    end
    // Store-and-forward frame, then a flush of a partial one
    bus(1'b1, 8'h74, 32'h001e0000);
    bus(1'b1, 8'h70, 32'h00000002);
    @(posedge sys_clk);
    chk(tx_active, 1'b1);
    sq.push_back({1'b1, 32'h4});
    words(4, 1'b1, 1'b1);
    drain();
    words(3, 1'b0, 1'b0);
    bus(1'b1, 8'h70, 32'h00004002);
    rd(8'h70, 32'h2);
    sq.push_back({1'b1, 32'h2});
    words(2, 1'b1, 1'b1);
    drain();
    // Status flush with the word left unread
    tx_stat_pop <= 1'b0;
    words(2, 1'b1, 1'b1);
    drain();
    repeat (4) @(posedge sys_clk);
    chk(tx_stat_valid, 1'b1);
    bus(1'b1, 8'h70, 32'h00008002);
    repeat (3) @(posedge sys_clk);
    chk(tx_stat_valid, 1'b0);
    tx_stat_pop <= 1'b1;
    // Halt during a stalled frame; clearing writes are ignored
    slow <= 1'b1;
    sq.push_back({1'b1, 32'h1e});
    words(30, 1'b1, 1'b1);
    bus(1'b1, 8'h70, 32'h3);
    bus(1'b1, 8'h70, 32'h2);
    rd(8'h70, 32'h3);
    n = 0;
    while (tx_active !== 1'b0) guard(n);
    rd(8'h70, 32'h0);
    drain();
    slow <= 1'b0;
    // Threshold start at 012h words, then host starvation
    bus(1'b1, 8'h74, 32'h002e0000);
    bus(1'b1, 8'h70, 32'h2);
    sq.push_back({1'b0, 32'h80000000});
    words(17, 1'b0, 1'b1);
    repeat (30) @(posedge sys_clk);
    chk(mac_tx_valid, 1'b0);
    words(1, 1'b0, 1'b1);
    n = 0;
    while (underruns == 0) guard(n);
    words(2, 1'b1, 1'b0);
    drain();
    chk(32'(underruns), 32'h1);
    // Unread status fills up; next frame waits until overrun allowed
    tx_stat_pop <= 1'b0;
    repeat (130) begin
      words(1, 1'b1, 1'b1);
      @(posedge sys_clk);
    end
    repeat (20) @(posedge sys_clk);
    chk(tx_stat_full, 1'b1);
    chk(33'(mq.size()), 33'h1);
    bus(1'b1, 8'h70, 32'h6);
    drain();
    chk(tx_stat_full, 1'b1);
    bus(1'b1, 8'h70, 32'h8002);
    tx_stat_pop <= 1'b1;
    finish_test();
  end
endmodule
`default_nettype wire

/* pkg/ftxc_consts.svh */
// Register map, field positions and reset values of the transmit control block
`ifndef FTXC_CONSTS_SVH
`define FTXC_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define FTXC_ADDR_TX_CFG 8'h70
`define FTXC_ADDR_HARDWARE_CONFIG 8'h74

// ----------------------------------------------------------------
// transmit_config fields
// ----------------------------------------------------------------
`define FTXC_BIT_STAT_FLUSH 15
`define FTXC_BIT_DATA_FLUSH 14
`define FTXC_BIT_OVR_ALLOW 2
`define FTXC_BIT_TX_ENABLE 1
`define FTXC_BIT_HALT_REQ 0

// ----------------------------------------------------------------
// hardware_config fields
// ----------------------------------------------------------------
`define FTXC_BIT_XOVER_STRAP 24
`define FTXC_BIT_THR_SPEED 21
`define FTXC_BIT_STORE_FWD 20
`define FTXC_ALLOC_HI 19
`define FTXC_ALLOC_LO 16
`define FTXC_THR_HI 13
`define FTXC_THR_LO 12
`define FTXC_ALLOC_RESET 4'h5
`define FTXC_ALLOC_MIN 4'h2
`define FTXC_ALLOC_MAX 4'he
`define FTXC_TOTAL_KB 5'h10

// ----------------------------------------------------------------
// Sizing in DWORDs and threshold table for threshold_speed_select = 1
// ----------------------------------------------------------------
`define FTXC_KB_PAD 8'h00
`define FTXC_STAT_DWORDS 13'h0080
`define FTXC_THR10_0 9'h012
`define FTXC_THR10_1 9'h018
`define FTXC_THR10_2 9'h020
`define FTXC_STAT_ERR_BIT 31

`endif

/* pkg/ftxc_pkg.sv */
// Types shared by the transmit control block
package ftxc_pkg;
  typedef enum logic [1:0] {
    FTXC_IDLE,
    FTXC_SEND,
    FTXC_DRAIN
  } ftxc_state_t;
endpackage

/* rtl/ftxc_fifo.sv */
// Flushable FIFO with a run-time capacity limit and a count of used words
`timescale 1ns/1ps
`default_nettype none
module ftxc_fifo #(
  parameter int WIDTH = 33,
  parameter int AW = 12
) (
  input wire logic clk, // System clock
  input wire logic reset, // Async reset, active high
  input wire logic flush, // Pointers back to zero
  input wire logic [AW:0] limit, // Usable capacity in words
  input wire logic push, // Write strobe
  input wire logic [WIDTH-1:0] push_data, // Write word
  input wire logic pop, // Read strobe
  output logic [WIDTH-1:0] rd_data, // Head word
  output logic [AW:0] count, // Words held
  output logic full, // At capacity
  output logic empty // Nothing held
);
  logic [WIDTH-1:0] mem [0:(1<<AW)-1];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] cnt_q;
  logic do_push;
  logic do_pop;

  // ----------------------------------------------------------------
  // Flow control
  // ----------------------------------------------------------------
  assign full = (cnt_q >= limit);
  assign empty = (cnt_q == '0);
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign count = cnt_q;
  assign rd_data = mem[rd_ptr_q];

  // Storage, no reset so it maps onto block memory
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_q] <= push_data;
    end
  end

  // Pointers; a shrunken limit only wraps at the physical depth
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (do_push && !do_pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (do_pop && !do_push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/ftxc_top.sv */
// Transmit control, FIFO configuration and register slave
`timescale 1ns/1ps
`default_nettype none
`include "ftxc_consts.svh"

module ftxc_top
  import ftxc_pkg::*;
#(
  parameter int DATA_AW = 12,
  parameter int STAT_AW = 7,
  parameter logic [8:0] THR10_3 = 9'h020,
  parameter logic [8:0] THR100_0 = 9'h008,
  parameter logic [8:0] THR100_1 = 9'h010,
  parameter logic [8:0] THR100_2 = 9'h018,
  parameter logic [8:0] THR100_3 = 9'h020
) (
  input wire logic sys_clk, // 250 MHz clock
  input wire logic reset, // Async reset, active high
  input wire logic [7:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [3:0] avs_byteenable, // Write lanes
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic crossover_auto_strap, // Strap pin level
  input wire logic tx_wr_valid, // Host word offered
  input wire logic [31:0] tx_wr_data, // Command or payload word
  input wire logic tx_wr_last, // Last word of frame
  output logic tx_wr_ready, // Data FIFO can take a word
  output logic mac_tx_valid, // Word to MAC valid
  output logic [31:0] mac_tx_data, // Word to MAC
  output logic mac_tx_last, // Last word of frame
  input wire logic mac_tx_ready, // MAC takes word
  output logic mac_tx_abort, // Frame abandoned, underrun
  output logic tx_stat_valid, // Status word ready
  output logic [31:0] tx_stat_data, // Status word
  input wire logic tx_stat_pop, // Host takes status
  output logic tx_stat_full, // Status FIFO full
  output logic tx_underrun, // Underrun event pulse
  output logic tx_active, // Transmitter enabled
  output logic [4:0] rx_alloc_kb // Receive share in KB
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic wait_q;
  logic [31:0] rdata_q;
  logic wr_acc;
  logic rd_acc;
  logic strap_s1_q;
  logic strap_s2_q;
  logic stat_flush_q;
  logic data_flush_q;
  logic ovr_allow_q;
  logic tx_on_q;
  logic halt_q;
  logic speed_sel_q;
  logic store_fwd_q;
  logic [3:0] alloc_q;
  logic [1:0] thr_code_q;
  logic [3:0] alloc_eff;
  logic [DATA_AW:0] data_limit;
  logic [STAT_AW:0] stat_limit;
  logic [8:0] thr_dw;
  ftxc_state_t state_q;
  logic [11:0] frames_q;
  logic [15:0] len_q;
  logic err_q;
  logic [32:0] d_rd;
  logic [DATA_AW:0] d_count;
  logic d_full;
  logic d_empty;
  logic d_push;
  logic d_pop;
  logic [31:0] s_rd;
  logic s_full;
  logic s_empty;
  logic s_push;
  logic s_pop;
  logic [31:0] s_word;
  logic out_free;
  logic start_ok;
  logic starve;
  logic frame_end;
  logic [12:0] data_dw;
  logic [12:0] thr_ext;

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // Write lands on the edge where the master sees waitrequest low
  assign wr_acc = avs_write && !wait_q;
  assign rd_acc = avs_read && wait_q;

  // One wait state per access, so read data can be registered
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wait_q <= 1'b1;
    end else if (!wait_q) begin
      wait_q <= 1'b1;
    end else if (avs_read || avs_write) begin
      wait_q <= 1'b0;
    end
  end

  // Read mux; unmapped addresses and reserved bits read zero
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_acc) begin
      rdata_q <= 32'h0000_0000;
      if (avs_address == `FTXC_ADDR_TX_CFG) begin
        rdata_q[`FTXC_BIT_STAT_FLUSH] <= stat_flush_q;
        rdata_q[`FTXC_BIT_DATA_FLUSH] <= data_flush_q;
        rdata_q[`FTXC_BIT_OVR_ALLOW] <= ovr_allow_q;
        rdata_q[`FTXC_BIT_TX_ENABLE] <= tx_on_q;
        rdata_q[`FTXC_BIT_HALT_REQ] <= halt_q;
      end else if (avs_address == `FTXC_ADDR_HARDWARE_CONFIG) begin
        rdata_q[`FTXC_BIT_XOVER_STRAP] <= strap_s2_q;
        rdata_q[`FTXC_BIT_THR_SPEED] <= speed_sel_q;
        rdata_q[`FTXC_BIT_STORE_FWD] <= store_fwd_q;
        rdata_q[`FTXC_ALLOC_HI:`FTXC_ALLOC_LO] <= alloc_q;
        rdata_q[`FTXC_THR_HI:`FTXC_THR_LO] <= thr_code_q;
      end
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

  // ----------------------------------------------------------------
  // Strap synchroniser
  // ----------------------------------------------------------------
  // Pin is asynchronous; the live level is reported, PHY overrides
  // act elsewhere and are not seen here
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
    end else begin
      strap_s1_q <= crossover_auto_strap;
      strap_s2_q <= strap_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // transmit_config
  // ----------------------------------------------------------------
  // Flush bits are one-cycle pulses: pointers clear on the next edge
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stat_flush_q <= 1'b0;
      data_flush_q <= 1'b0;
    end else begin
      stat_flush_q <= 1'b0;
      data_flush_q <= 1'b0;
      if (wr_acc && avs_address == `FTXC_ADDR_TX_CFG &&
          avs_byteenable[1]) begin
        stat_flush_q <= avs_writedata[`FTXC_BIT_STAT_FLUSH];
        data_flush_q <= avs_writedata[`FTXC_BIT_DATA_FLUSH];
      end
    end
  end

  // Overrun policy bit
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ovr_allow_q <= 1'b0;
    end else if (wr_acc && avs_address == `FTXC_ADDR_TX_CFG &&
                 avs_byteenable[0]) begin
      ovr_allow_q <= avs_writedata[`FTXC_BIT_OVR_ALLOW];
    end
  end

  // Enable and halt; halt completes only between frames
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tx_on_q <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      if (halt_q && state_q == FTXC_IDLE) begin
        halt_q <= 1'b0;
        tx_on_q <= 1'b0;
      end else if (wr_acc && avs_address == `FTXC_ADDR_TX_CFG &&
                   avs_byteenable[0]) begin
        tx_on_q <= avs_writedata[`FTXC_BIT_TX_ENABLE];
        if (!halt_q) begin
          halt_q <= avs_writedata[`FTXC_BIT_HALT_REQ];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // hardware_config
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      speed_sel_q <= 1'b0;
      store_fwd_q <= 1'b0;
      alloc_q <= `FTXC_ALLOC_RESET;
      thr_code_q <= 2'h0;
    end else if (wr_acc && avs_address == `FTXC_ADDR_HARDWARE_CONFIG) begin
      if (avs_byteenable[2]) begin
        speed_sel_q <= avs_writedata[`FTXC_BIT_THR_SPEED];
        store_fwd_q <= avs_writedata[`FTXC_BIT_STORE_FWD];
        alloc_q <= avs_writedata[`FTXC_ALLOC_HI:`FTXC_ALLOC_LO];
      end
      if (avs_byteenable[1]) begin
        thr_code_q <= avs_writedata[`FTXC_THR_HI:`FTXC_THR_LO];
      end
    end
  end

  // ----------------------------------------------------------------
  // FIFO partitioning
  // ----------------------------------------------------------------
  // Out-of-range codes are clamped rather than trusted
  always_comb begin
    if (alloc_q < `FTXC_ALLOC_MIN) begin
      alloc_eff = `FTXC_ALLOC_MIN;
    end else if (alloc_q > `FTXC_ALLOC_MAX) begin
      alloc_eff = `FTXC_ALLOC_MAX;
    end else begin
      alloc_eff = alloc_q;
    end
  end

  // Status keeps 128 DWORDs, data takes the rest of the allocation
  assign data_dw = {1'b0, alloc_eff, `FTXC_KB_PAD} - `FTXC_STAT_DWORDS;
  assign data_limit = (DATA_AW + 1)'(data_dw);
  assign stat_limit = (STAT_AW + 1)'(`FTXC_STAT_DWORDS);

  // Receive share is reported for the receive side to size itself
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rx_alloc_kb <= `FTXC_TOTAL_KB - {1'b0, `FTXC_ALLOC_RESET};
    end else begin
      rx_alloc_kb <= `FTXC_TOTAL_KB - {1'b0, alloc_eff};
    end
  end

  // ----------------------------------------------------------------
  // Start threshold
  // ----------------------------------------------------------------
  always_comb begin
    thr_dw = THR100_0;
    unique case ({speed_sel_q, thr_code_q})
      3'h4: thr_dw = `FTXC_THR10_0;
      3'h5: thr_dw = `FTXC_THR10_1;
      3'h6: thr_dw = `FTXC_THR10_2;
      3'h7: thr_dw = THR10_3;
      3'h0: thr_dw = THR100_0;
      3'h1: thr_dw = THR100_1;
      3'h2: thr_dw = THR100_2;
      3'h3: thr_dw = THR100_3;
    endcase
  end
  assign thr_ext = {4'h0, thr_dw};

  // ----------------------------------------------------------------
  // Data FIFO: command words and payload in one store
  // ----------------------------------------------------------------
  assign d_push = tx_wr_valid && tx_wr_ready;

  ftxc_fifo #(
    .WIDTH(33),
    .AW(DATA_AW)
  ) u_data_fifo (
    .clk(sys_clk),
    .reset(reset),
    .flush(data_flush_q),
    .limit(data_limit),
    .push(d_push),
    .push_data({tx_wr_last, tx_wr_data}),
    .pop(d_pop),
    .rd_data(d_rd),
    .count(d_count),
    .full(d_full),
    .empty(d_empty)
  );

  // Two words of slack so a registered ready cannot overfill
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tx_wr_ready <= 1'b0;
    end else begin
      tx_wr_ready <= !data_flush_q && !d_full &&
                     ((d_count + 2'd2) <= data_limit);
    end
  end

  // Complete frames held, for store-and-forward starts
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      frames_q <= 12'h000;
    end else if (data_flush_q) begin
      frames_q <= 12'h000;
    end else begin
      frames_q <= frames_q + 12'(d_push && tx_wr_last)
                           - 12'(d_pop && d_rd[32]);
    end
  end

  // ----------------------------------------------------------------
  // Transmit engine
  // ----------------------------------------------------------------
  assign out_free = !mac_tx_valid || mac_tx_ready;

  // Suspend at a frame boundary when status would overflow
  assign start_ok = tx_on_q && !halt_q && !d_empty &&
                    !(s_full && !ovr_allow_q) &&
                    (store_fwd_q ? (frames_q != 12'h000) :
                     ((frames_q != 12'h000) ||
                      (32'(d_count) >= 32'(thr_ext))));

  // Host fell behind the MAC mid-frame; not possible in store-forward
  assign starve = (state_q == FTXC_SEND) && d_empty && out_free;

  assign d_pop = ((state_q == FTXC_SEND) && out_free && !d_empty) ||
                 (state_q == FTXC_DRAIN && !d_empty);

  assign frame_end = d_pop && d_rd[32];

  // Frame sequencing; a data flush abandons any frame in flight
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= FTXC_IDLE;
    end else if (data_flush_q) begin
      state_q <= FTXC_IDLE;
    end else begin
      unique case (state_q)
        FTXC_IDLE: if (start_ok) begin
          state_q <= FTXC_SEND;
        end
        FTXC_SEND: if (frame_end) begin
          state_q <= FTXC_IDLE;
        end else if (starve) begin
          state_q <= FTXC_DRAIN;
        end
        FTXC_DRAIN: if (frame_end) begin
          state_q <= FTXC_IDLE;
        end
      endcase
    end
  end

  // Output stage towards the MAC
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mac_tx_valid <= 1'b0;
      mac_tx_data <= 32'h0000_0000;
      mac_tx_last <= 1'b0;
    end else if (data_flush_q) begin
      mac_tx_valid <= 1'b0;
    end else if (out_free) begin
      mac_tx_valid <= d_pop && (state_q == FTXC_SEND);
      mac_tx_data <= d_rd[31:0];
      mac_tx_last <= d_rd[32];
    end
  end

  // Underrun reporting
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tx_underrun <= 1'b0;
      mac_tx_abort <= 1'b0;
      err_q <= 1'b0;
    end else begin
      tx_underrun <= starve && !data_flush_q;
      mac_tx_abort <= starve && !data_flush_q;
      if (data_flush_q || (state_q == FTXC_IDLE)) begin
        err_q <= 1'b0;
      end else if (starve) begin
        err_q <= 1'b1;
      end
    end
  end

  // Frame length in words for the status word
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      len_q <= 16'h0000;
    end else if (state_q == FTXC_IDLE) begin
      len_q <= 16'h0000;
    end else if (d_pop) begin
      len_q <= len_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Status FIFO
  // ----------------------------------------------------------------
  // With overrun allowed a word pushed into a full FIFO is lost
  assign s_push = frame_end && !data_flush_q;
  assign s_word = {err_q || starve, 15'h0000, len_q + 16'h0001};

  ftxc_fifo #(
    .WIDTH(32),
    .AW(STAT_AW)
  ) u_stat_fifo (
    .clk(sys_clk),
    .reset(reset),
    .flush(stat_flush_q),
    .limit(stat_limit),
    .push(s_push),
    .push_data(s_word),
    .pop(s_pop),
    .rd_data(s_rd),
    .count(),
    .full(s_full),
    .empty(s_empty)
  );

  assign s_pop = !s_empty && !stat_flush_q &&
                 (!tx_stat_valid || tx_stat_pop);

  // Registered head of the status FIFO for the host
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tx_stat_valid <= 1'b0;
      tx_stat_data <= 32'h0000_0000;
    end else if (stat_flush_q) begin
      tx_stat_valid <= 1'b0;
    end else if (!tx_stat_valid || tx_stat_pop) begin
      tx_stat_valid <= s_pop;
      tx_stat_data <= s_rd;
    end
  end

  // Full flag ignores the overrun policy
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tx_stat_full <= 1'b0;
      tx_active <= 1'b0;
    end else begin
      tx_stat_full <= s_full;
      tx_active <= tx_on_q;
    end
  end
endmodule
`default_nettype wire
